// ==== src/adcsq_ctrl.sv ====
`timescale 1ns/1ps
// Overview of operation
// R01: Converter control registers are written only while no conversion runs, go bit excepted.
// R02: The standby-release bit is cleared only after the conversion has stopped.
// R03: After standby release, at least one conversion-clock cycle passes before a start.
// R04: Every mode change is followed by a fresh channel or sweep-group selection.
// R05: Clearing the go bit mid-conversion abandons it and leaves results undefined.
// R06: After a software abort no result register is used.
// R07: Assist field is changed, one conversion-clock cycle passes, then go is set.
// R08: Completion is seen on the interrupt request flag, which is then cleared by software.
// R09: The go bit may read back zero shortly after being written, so it is not polled.
// R10: The clock-source bit is written first, and the other registers after it.
// R11: The conversion clock lies between 2 MHz and a supply-dependent ceiling of 25, 16 or 10 MHz.
// R12: Key-capable inputs are never selected while the key interrupt is in use.
// R13: In one-shot mode the device clears the go bit itself at completion.
module adcsq_ctrl (
  input  wire logic                       pclk,      // System clock, 10 MHz.
  input  wire logic                       presetn,   // Asynchronous reset, active low.
  input  wire logic                       psel,      // APB select.
  input  wire logic                       penable,   // APB enable.
  input  wire logic                       pwrite,    // APB direction.
  input  wire logic [11:0]                paddr,     // APB byte address.
  input  wire logic [31:0]                pwdata,    // APB write data.
  output logic      [31:0]                prdata,    // APB read data.
  output logic                            pready,    // APB ready.
  output logic                            pslverr,   // APB error on unmapped address.
  output logic                            irq,       // Level interrupt.
  output adcsq_pkg::adcsq_dev_req_t       dev_req,   // Device register request.
  input  wire logic [7:0]                 dev_rdata  // Device register read data.
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  adcsq_pkg::adcsq_state_t   state_q, state_d;
  adcsq_pkg::adcsq_cfg_t     cfg_q;
  adcsq_pkg::adcsq_dev_req_t req_d;
  logic [31:0] prdata_q;
  logic        slverr_q;
  logic [2:0]  istat_q, imask_q;
  logic [7:0]  result_q, rd_sync;
  logic        res_valid_q, conv_active_q;
  logic [3:0]  cnt_q;
  logic        tick, wr_acc, start_cmd, abort_cmd, stop_cmd, key_bad;
  logic        tick_wait, read_wait, wait_done, flag_seen, refuse;

  // Builds the first control register image from configuration and go.
  function automatic logic [7:0] ctl1_image(adcsq_pkg::adcsq_cfg_t c, logic go);
    logic [7:0] v;
    v = 8'h00;
    v[adcsq_pkg::CH_LSB +: 3]   = c.chan;
    v[adcsq_pkg::MODE_LSB +: 2] = c.mode;
    v[adcsq_pkg::GO_BIT]        = go;
    return v;
  endfunction

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign wr_acc    = psel && penable && pwrite;
  assign pready    = psel && penable;
  assign pslverr   = pready && slverr_q;
  assign prdata    = prdata_q;
  assign start_cmd = wr_acc && paddr == adcsq_pkg::OFS_CTRL && pwdata[adcsq_pkg::CTRL_START_BIT];
  assign abort_cmd = wr_acc && paddr == adcsq_pkg::OFS_CTRL && pwdata[adcsq_pkg::CTRL_ABORT_BIT];
  assign stop_cmd  = wr_acc && paddr == adcsq_pkg::OFS_CTRL && pwdata[adcsq_pkg::CTRL_STOP_BIT];

  // Read data and error are captured in the setup cycle, so the slave never waits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (psel && !penable) begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
      unique case (paddr)
        adcsq_pkg::OFS_CTRL:   prdata_q <= 32'h0000_0000;
        adcsq_pkg::OFS_CFG:    prdata_q <= 32'(cfg_q);
        adcsq_pkg::OFS_STATUS: prdata_q <= {25'h0, state_q, res_valid_q, conv_active_q,
                                             state_q != adcsq_pkg::ST_IDLE};
        adcsq_pkg::OFS_RESULT: prdata_q <= {24'h0, result_q};
        adcsq_pkg::OFS_ISTAT:  prdata_q <= {29'h0, istat_q};
        adcsq_pkg::OFS_IMASK:  prdata_q <= {29'h0, imask_q};
        default:               slverr_q <= 1'b1;
      endcase
    end
  end

  // Configuration and mask registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q   <= '0;
      imask_q <= 3'h0;
    end else if (wr_acc && paddr == adcsq_pkg::OFS_CFG) begin
      cfg_q <= pwdata[adcsq_pkg::CFG_W-1:0];
    end else if (wr_acc && paddr == adcsq_pkg::OFS_IMASK) begin
      imask_q <= pwdata[adcsq_pkg::IRQ_W-1:0];
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  // Key-capable input while the key interrupt is in use.
  assign key_bad = cfg_q.key_use && cfg_q.chan >= adcsq_pkg::KEY_FIRST_CH;
  assign refuse  = start_cmd && (state_q != adcsq_pkg::ST_IDLE || key_bad);

  // Sticky events; a new event in the clearing cycle survives the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_q <= 3'h0;
    end else begin
      istat_q <= (istat_q & ~((wr_acc && paddr == adcsq_pkg::OFS_ISTAT) ?
                              pwdata[adcsq_pkg::IRQ_W-1:0] : 3'h0))
               | {refuse, state_q == adcsq_pkg::ST_ABORT,
                  state_q == adcsq_pkg::ST_RES_WAIT && wait_done};
    end
  end

  assign irq = |(istat_q & imask_q);

  // ****************************************************************
  // Timing helpers
  // ****************************************************************
  assign tick_wait = state_q == adcsq_pkg::ST_WAIT_STBY || state_q == adcsq_pkg::ST_WAIT_ASSIST;
  assign read_wait = state_q == adcsq_pkg::ST_POLL_WAIT || state_q == adcsq_pkg::ST_RES_WAIT;
  assign wait_done = tick_wait ? cnt_q >= adcsq_pkg::WAIT_TICKS
                               : cnt_q >= adcsq_pkg::READ_WAIT_CYC;

  // R11 slowest clock
  adcsq_tick_div u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (tick_wait),
    .tick    (tick)
  );

  adcsq_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (dev_rdata),
    .dout    (rd_sync)
  );

  // Wait counter counts divider ticks or plain cycles and restarts on each state change.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
    end else if (state_d != state_q) begin
      cnt_q <= 4'h0;
    end else if ((tick_wait && tick) || (read_wait && !wait_done)) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // R08 completion flag
  assign flag_seen = state_q == adcsq_pkg::ST_POLL_WAIT && wait_done
                     && rd_sync[adcsq_pkg::IRQFLAG_BIT] && !abort_cmd;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Fixed order: clock source, third, second, settle, assist, settle, first, go.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      adcsq_pkg::ST_IDLE: begin
        // R12 refuse key pins
        if (start_cmd && !key_bad) begin
          state_d = adcsq_pkg::ST_WR_CLK;
        end else if (stop_cmd) begin
          state_d = adcsq_pkg::ST_STOP_STBY;
        end
      end
      // R10 clock first
      adcsq_pkg::ST_WR_CLK:      state_d = adcsq_pkg::ST_WR_CTL3;
      adcsq_pkg::ST_WR_CTL3:     state_d = adcsq_pkg::ST_WR_CTL2;
      adcsq_pkg::ST_WR_CTL2:     state_d = adcsq_pkg::ST_WAIT_STBY;
      adcsq_pkg::ST_WAIT_STBY: begin
        // R03 standby settle
        if (wait_done) begin
          state_d = adcsq_pkg::ST_WR_ASSIST;
        end
      end
      adcsq_pkg::ST_WR_ASSIST:   state_d = adcsq_pkg::ST_WAIT_ASSIST;
      adcsq_pkg::ST_WAIT_ASSIST: begin
        // R07 assist settle
        if (wait_done) begin
          state_d = adcsq_pkg::ST_WR_CTL1;
        end
      end
      adcsq_pkg::ST_WR_CTL1:     state_d = adcsq_pkg::ST_WR_GO;
      adcsq_pkg::ST_WR_GO:       state_d = adcsq_pkg::ST_POLL_RD;
      adcsq_pkg::ST_POLL_RD: begin
        state_d = abort_cmd ? adcsq_pkg::ST_ABORT : adcsq_pkg::ST_POLL_WAIT;
      end
      adcsq_pkg::ST_POLL_WAIT: begin
        // R09 poll flag only
        if (abort_cmd) begin
          state_d = adcsq_pkg::ST_ABORT;
        end else if (flag_seen) begin
          state_d = adcsq_pkg::ST_CLR_FLAG;
        end else if (wait_done) begin
          state_d = adcsq_pkg::ST_POLL_RD;
        end
      end
      adcsq_pkg::ST_CLR_FLAG:    state_d = adcsq_pkg::ST_RES_RD;
      adcsq_pkg::ST_RES_RD:      state_d = adcsq_pkg::ST_RES_WAIT;
      adcsq_pkg::ST_RES_WAIT: begin
        if (wait_done) begin
          state_d = adcsq_pkg::ST_IDLE;
        end
      end
      adcsq_pkg::ST_ABORT:       state_d = adcsq_pkg::ST_IDLE;
      adcsq_pkg::ST_STOP_STBY:   state_d = adcsq_pkg::ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= adcsq_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // Device register port
  // ****************************************************************
  // Request image per state; registered so the pins never glitch.
  always_comb begin
    req_d = '0;
    unique case (state_q)
      adcsq_pkg::ST_WR_CLK: begin
        req_d.sel = 1'b1;
        req_d.wr  = 1'b1;
        req_d.addr = adcsq_pkg::DEV_CLKSRC;
        req_d.wdata[adcsq_pkg::CLKSRC_BIT] = cfg_q.clk_src;
      end
      adcsq_pkg::ST_WR_CTL3: begin
        req_d.sel = 1'b1;
        req_d.wr  = 1'b1;
        req_d.addr = adcsq_pkg::DEV_CTL3;
        req_d.wdata = adcsq_pkg::CTL3_VALUE;
      end
      adcsq_pkg::ST_WR_CTL2: begin
        // R04 sweep reselect
        req_d.sel = 1'b1;
        req_d.wr  = 1'b1;
        req_d.addr = adcsq_pkg::DEV_CTL2;
        req_d.wdata[adcsq_pkg::SWEEP_LSB +: 2] = cfg_q.sweep;
        req_d.wdata[adcsq_pkg::STBY_BIT] = 1'b1;
      end
      adcsq_pkg::ST_WR_ASSIST: begin
        req_d.sel = 1'b1;
        req_d.wr  = 1'b1;
        req_d.addr = adcsq_pkg::DEV_ASSIST;
        req_d.wdata[adcsq_pkg::ASSIST_LSB +: 2] = cfg_q.assist;
      end
      adcsq_pkg::ST_WR_CTL1, adcsq_pkg::ST_WR_GO: begin
        // R04 channel reselect
        req_d.sel = 1'b1;
        req_d.wr  = 1'b1;
        req_d.addr = adcsq_pkg::DEV_CTL1;
        req_d.wdata = ctl1_image(cfg_q, state_q == adcsq_pkg::ST_WR_GO);
      end
      adcsq_pkg::ST_POLL_RD, adcsq_pkg::ST_POLL_WAIT: begin
        req_d.sel = 1'b1;
        req_d.addr = adcsq_pkg::DEV_IRQCTL;
      end
      adcsq_pkg::ST_CLR_FLAG: begin
        // R08 clear flag
        req_d.sel = 1'b1;
        req_d.wr  = 1'b1;
        req_d.addr = adcsq_pkg::DEV_IRQCTL;
      end
      adcsq_pkg::ST_RES_RD, adcsq_pkg::ST_RES_WAIT: begin
        req_d.sel = 1'b1;
        req_d.addr = adcsq_pkg::DEV_RESULT;
      end
      adcsq_pkg::ST_ABORT: begin
        // R05 go cleared
        req_d.sel = 1'b1;
        req_d.wr  = 1'b1;
        req_d.addr = adcsq_pkg::DEV_CTL1;
        req_d.wdata = ctl1_image(cfg_q, 1'b0);
      end
      adcsq_pkg::ST_STOP_STBY: begin
        // R02 stopped first
        req_d.sel = 1'b1;
        req_d.wr  = 1'b1;
        req_d.addr = adcsq_pkg::DEV_CTL2;
        req_d.wdata[adcsq_pkg::SWEEP_LSB +: 2] = cfg_q.sweep;
      end
      default: req_d = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_req <= '0;
    end else begin
      dev_req <= req_d;
    end
  end

  // R01 conversion tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_active_q <= 1'b0;
    end else if (state_q == adcsq_pkg::ST_WR_GO) begin
      conv_active_q <= 1'b1;
    end else if (state_q == adcsq_pkg::ST_ABORT || flag_seen) begin
      conv_active_q <= 1'b0;
    end
  end

  // R06 result discarded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q    <= 8'h00;
      res_valid_q <= 1'b0;
    end else if (state_q == adcsq_pkg::ST_WR_CLK || state_q == adcsq_pkg::ST_ABORT) begin
      res_valid_q <= 1'b0;
    end else if (state_q == adcsq_pkg::ST_RES_WAIT && wait_done) begin
      result_q    <= rd_sync;
      res_valid_q <= 1'b1;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_CLK_FIRST: assert property (@(posedge pclk) disable iff (!presetn) // R10
    dev_req.sel && dev_req.wr && dev_req.addr == adcsq_pkg::DEV_CTL3
      |-> $past(dev_req.addr) == adcsq_pkg::DEV_CLKSRC && $past(dev_req.wr))
    else $error("Third control written before the clock source.");

  AST_STBY_SETTLE: assert property (@(posedge pclk) disable iff (!presetn) // R03
    $rose(state_q == adcsq_pkg::ST_WAIT_STBY) |-> (state_q == adcsq_pkg::ST_WAIT_STBY)[*5])
    else $error("Standby settle shorter than one conversion-clock period.");

  AST_ASSIST_SETTLE: assert property (@(posedge pclk) disable iff (!presetn) // R07
    $rose(state_q == adcsq_pkg::ST_WAIT_ASSIST)
      |-> (state_q == adcsq_pkg::ST_WAIT_ASSIST)[*8] ##1 (state_q == adcsq_pkg::ST_WAIT_ASSIST)[*3]
      ##1 state_q == adcsq_pkg::ST_WR_CTL1)
    else $error("Go set too soon after the assist change.");

  AST_GO_AFTER_CH: assert property (@(posedge pclk) disable iff (!presetn) // R04
    dev_req.wr && dev_req.wdata[adcsq_pkg::GO_BIT] && dev_req.addr == adcsq_pkg::DEV_CTL1
      |-> $past(dev_req.addr) == adcsq_pkg::DEV_CTL1 && !$past(dev_req.wdata[adcsq_pkg::GO_BIT]))
    else $error("Go set without a fresh channel selection.");

  AST_NO_CFG_BUSY: assert property (@(posedge pclk) disable iff (!presetn) // R01
    dev_req.sel && dev_req.wr && conv_active_q |-> dev_req.addr == adcsq_pkg::DEV_CTL1)
    else $error("Control register written during a conversion.");

  AST_STBY_OFF: assert property (@(posedge pclk) disable iff (!presetn) // R02
    dev_req.sel && dev_req.wr && dev_req.addr == adcsq_pkg::DEV_CTL2
      && !dev_req.wdata[adcsq_pkg::STBY_BIT] |-> !conv_active_q)
    else $error("Standby cleared while converting.");

  AST_FLAG_CLEAR: assert property (@(posedge pclk) disable iff (!presetn) // R08
    flag_seen |-> ##2 dev_req.sel && dev_req.wr && dev_req.addr == adcsq_pkg::DEV_IRQCTL
      && !dev_req.wdata[adcsq_pkg::IRQFLAG_BIT])
    else $error("Completion flag not cleared two cycles after detection.");

  AST_ABORT_NORES: assert property (@(posedge pclk) disable iff (!presetn) // R06
    state_q == adcsq_pkg::ST_ABORT |=> !res_valid_q && state_q == adcsq_pkg::ST_IDLE)
    else $error("Result kept valid after an abort.");

  AST_KEY_REFUSE: assert property (@(posedge pclk) disable iff (!presetn) // R12
    state_q == adcsq_pkg::ST_IDLE && start_cmd && key_bad |=> state_q == adcsq_pkg::ST_IDLE
      ##1 istat_q[adcsq_pkg::IRQ_REFUSE_BIT])
    else $error("Start accepted on a key-capable input.");

endmodule

// ==== common/adcsq_pkg.sv ====
package adcsq_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int PCLK_HZ         = 10_000_000;
  // Slowest legal conversion clock; one of its periods covers every legal setting.
  localparam int CONV_CLK_MIN_HZ = 2_000_000;
  localparam int CONV_CLK_MAX_HZ = 25_000_000;
  localparam int PHI_DIV_CYC     = (PCLK_HZ + CONV_CLK_MIN_HZ - 1) / CONV_CLK_MIN_HZ;
  localparam logic [2:0] PHI_DIV_LAST  = 3'(PHI_DIV_CYC - 1);
  // Two ticks of the divider always span one whole conversion-clock period.
  localparam logic [3:0] WAIT_TICKS    = 4'h2;
  // Read data crosses two synchroniser stages plus one cycle of settling.
  localparam logic [3:0] READ_WAIT_CYC = 4'h3;

  // ****************************************************************
  // Own register map, APB byte addresses
  // ****************************************************************
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_CFG    = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_RESULT = 12'h00C;
  localparam logic [11:0] OFS_ISTAT  = 12'h010;
  localparam logic [11:0] OFS_IMASK  = 12'h014;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ABORT_BIT = 1;
  localparam int CTRL_STOP_BIT  = 2;
  localparam int IRQ_W          = 3;
  localparam int IRQ_DONE_BIT   = 0;
  localparam int IRQ_ABORT_BIT  = 1;
  localparam int IRQ_REFUSE_BIT = 2;
  localparam int CFG_W          = 11;

  // ****************************************************************
  // Device register port
  // ****************************************************************
  localparam int DEV_DATA_W = 8;
  localparam logic [2:0] DEV_CTL1   = 3'h0;
  localparam logic [2:0] DEV_CTL2   = 3'h1;
  localparam logic [2:0] DEV_CTL3   = 3'h2;
  localparam logic [2:0] DEV_CLKSRC = 3'h3;
  localparam logic [2:0] DEV_ASSIST = 3'h4;
  localparam logic [2:0] DEV_IRQCTL = 3'h5;
  localparam logic [2:0] DEV_RESULT = 3'h6;

  localparam int CH_LSB      = 0;
  localparam int MODE_LSB    = 3;
  localparam int GO_BIT      = 6;
  localparam int SWEEP_LSB   = 0;
  localparam int STBY_BIT    = 5;
  localparam int CLKSRC_BIT  = 0;
  localparam int ASSIST_LSB  = 0;
  localparam int IRQFLAG_BIT = 3;
  localparam logic [7:0] CTL3_VALUE = 8'h00;
  localparam logic [2:0] KEY_FIRST_CH = 3'h4;

  typedef struct packed {
    logic       sel;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } adcsq_dev_req_t;

  typedef struct packed {
    logic       key_use;
    logic       clk_src;
    logic [1:0] assist;
    logic [1:0] mode;
    logic [1:0] sweep;
    logic [2:0] chan;
  } adcsq_cfg_t;

  typedef enum logic [3:0] {
    ST_IDLE        = 4'h0,
    ST_WR_CLK      = 4'h1,
    ST_WR_CTL3     = 4'h2,
    ST_WR_CTL2     = 4'h3,
    ST_WAIT_STBY   = 4'h4,
    ST_WR_ASSIST   = 4'h5,
    ST_WAIT_ASSIST = 4'h6,
    ST_WR_CTL1     = 4'h7,
    ST_WR_GO       = 4'h8,
    ST_POLL_RD     = 4'h9,
    ST_POLL_WAIT   = 4'hA,
    ST_CLR_FLAG    = 4'hB,
    ST_RES_RD      = 4'hC,
    ST_RES_WAIT    = 4'hD,
    ST_ABORT       = 4'hE,
    ST_STOP_STBY   = 4'hF
  } adcsq_state_t;

endpackage

// ==== src/adcsq_tick_div.sv ====
`timescale 1ns/1ps
module adcsq_tick_div (
  input  wire logic pclk,    // System clock.
  input  wire logic presetn, // Asynchronous reset, active low.
  input  wire logic run,     // Counts while high, restarts when low.
  output logic      tick     // One-cycle pulse per conversion-clock period.
);

  logic [2:0] cnt_q;

  // Counter restarts on every idle cycle so each wait starts from a clean phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 3'h0;
    end else if (!run || cnt_q == adcsq_pkg::PHI_DIV_LAST) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  assign tick = run && (cnt_q == adcsq_pkg::PHI_DIV_LAST);

endmodule

// ==== src/adcsq_sync.sv ====
`timescale 1ns/1ps
module adcsq_sync (
  input  wire logic       pclk,    // System clock.
  input  wire logic       presetn, // Asynchronous reset, active low.
  input  wire logic [7:0] din,     // Asynchronous input bus.
  output logic      [7:0] dout     // Synchronised copy.
);

  logic [7:0] meta_q;

  // Two stages; the first is read by the second only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 8'h00;
      dout   <= 8'h00;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule

// ==== verif/adcsq_dev_model.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Converter register file seen from its control pins
// ****************************************************************
module adcsq_dev_model (
  input  wire logic                     pclk,    // System clock.
  input  wire logic                     presetn, // Reset, active low.
  input  wire adcsq_pkg::adcsq_dev_req_t req,    // Register request.
  input  wire logic [7:0]               sample,  // Value the next conversion yields.
  output logic      [7:0]               rdata,   // Register read data.
  output int                            viol     // Ordering faults seen.
);
  logic [7:0] regs_q [8];
  logic [7:0] last_q;
  logic       clk_set_q;
  int         since_q;
  int         busy_q;

  // A released bus shows the inverse of the last value, never a stale copy.
  assign rdata = (req.sel && !req.wr) ? regs_q[req.addr] : ~last_q;

  // Conversion engine and write checks; one period at 2 MHz is 5 system cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) regs_q[i] <= 8'h00;
      {last_q, clk_set_q, since_q, busy_q, viol} <= '0;
    end else begin
      last_q  <= rdata;
      since_q <= since_q + 1;
      if (busy_q > 0) busy_q <= busy_q - 1;
      if (busy_q == 28) regs_q[0][6] <= 1'b1;
      if (busy_q == 1) begin
        regs_q[6]    <= sample;
        regs_q[5][3] <= 1'b1;
        regs_q[0][6] <= 1'b0;
      end
      if (req.sel && req.wr) begin
        regs_q[req.addr] <= req.wdata & ((req.addr == 3'h0) ? 8'hBF : 8'hFF);
        if (req.addr == 3'h3) clk_set_q <= 1'b1;
        else if (!clk_set_q) viol <= viol + 1;
        if (busy_q > 0 && req.addr != 3'h0) viol <= viol + 1;
        if (req.addr == 3'h1 || req.addr == 3'h4) since_q <= 0;
        if (req.addr == 3'h0 && req.wdata[6]) begin
          if (since_q < 5) viol <= viol + 1;
          busy_q <= 30;
        end
        if (req.addr == 3'h0 && !req.wdata[6] && busy_q > 0) begin
          busy_q    <= 0;
          regs_q[6] <= ~sample;
        end
      end
    end
  end
endmodule

// ==== verif/adcsq_ctrl_bench.sv ====
`timescale 1ns/1ps
module adcsq_ctrl_bench;
  logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0]               paddr;
  logic [31:0]               pwdata, prdata, rd, cfg_w;
  logic [7:0]                dev_rdata, sample;
  adcsq_pkg::adcsq_dev_req_t dev_req;
  int                        error_cnt, checks, viol, cyc;

  adcsq_ctrl i_adcsq_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .dev_req(dev_req), .dev_rdata(dev_rdata));
  adcsq_dev_model i_adcsq_dev_model (.pclk(pclk), .presetn(presetn), .req(dev_req),
    .sample(sample), .rdata(dev_rdata), .viol(viol));

  // ****************************************************************
  // Clock, timeout and shared tasks
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // A hang ends the run through the normal report.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  // One APB transfer; waits on pready with no assumed latency.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  task automatic wait_irq();
    for (int i = 0; i < 300 && irq !== 1'b1; i++) @(posedge pclk);
  endtask

  task automatic close_out();
    $display("error_cnt %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, sample, presetn} = '0;
    {error_cnt, checks, cyc} = '0;
    rd = $urandom(32'h2A0136A3);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, adcsq_pkg::OFS_IMASK, 32'h7);
    apb(1'b0, 12'h040, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped not refused");
    // Every mode, random channel, sweep and assist; the model yields the result.
    for (int m = 0; m < 4; m++) begin
      sample <= 8'($urandom);
      cfg_w = {22'h0, 10'($urandom) & 10'h39F} | 32'(m << 5);
      apb(1'b1, adcsq_pkg::OFS_CFG, cfg_w);
      apb(1'b0, adcsq_pkg::OFS_CFG, 32'h0);
      chk(rd, cfg_w, "config readback");
      apb(1'b1, adcsq_pkg::OFS_CTRL, 32'h1);
      wait_irq();
      apb(1'b0, adcsq_pkg::OFS_ISTAT, 32'h0);
      chk(rd, 32'h1, "done not flagged");
      apb(1'b0, adcsq_pkg::OFS_RESULT, 32'h0);
      chk(rd, {24'h0, sample}, "result");
      apb(1'b1, adcsq_pkg::OFS_ISTAT, 32'h1);
      // The clear lands at the access edge, so irq is looked at one edge later.
      @(posedge pclk);
      chk({31'h0, irq}, 32'h0, "irq not cleared");
    end
    // Key-capable channel with key use is refused; then masked.
    apb(1'b1, adcsq_pkg::OFS_CFG, 32'h405);
    apb(1'b1, adcsq_pkg::OFS_CTRL, 32'h1);
    apb(1'b0, adcsq_pkg::OFS_ISTAT, 32'h0);
    chk(rd, 32'h4, "key channel accepted");
    apb(1'b1, adcsq_pkg::OFS_IMASK, 32'h3);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0, "masked irq high");
    apb(1'b1, adcsq_pkg::OFS_ISTAT, 32'h7);
    // Abort while polling: result no longer valid.
    apb(1'b1, adcsq_pkg::OFS_CFG, 32'h002);
    apb(1'b1, adcsq_pkg::OFS_CTRL, 32'h1);
    repeat (32) @(posedge pclk);
    apb(1'b1, adcsq_pkg::OFS_CTRL, 32'h2);
    repeat (20) @(posedge pclk);
    apb(1'b0, adcsq_pkg::OFS_ISTAT, 32'h0);
    chk(rd, 32'h2, "abort not flagged");
    apb(1'b0, adcsq_pkg::OFS_STATUS, 32'h0);
    chk(rd & 32'h4, 32'h0, "result still valid");
    apb(1'b1, adcsq_pkg::OFS_CTRL, 32'h4);
    repeat (10) @(posedge pclk);
    chk(32'(viol), 32'h0, "device ordering");
    close_out();
  end
endmodule
